// file: design/fan_pwm_duty_source_control.v
// Fan PWM controller: start-up full drive, duty source selection, over-temperature
// Overview of operation
// - After reset and on leaving shutdown the drive is held at full duty for one second.
// - When that period ends the source select picks the analog level or the duty setting register.
// - The source select is taken live from the i_duty_source_select input and has no reset value here.
// - With the analog source selected and the input open, the duty is the 39.33% default.
// - With analog control the 1.62 V to 2.6 V span maps linearly onto 30% to 100% duty.
// - Below the span the analog duty stays clamped at the 30% floor.
// - Above the over-temperature level, unless the input is open, the over-temperature flag reads one.
// - In the pin-reporting variant the fault line is pulled low while over-temperature lasts.
// - The source select may change at any time and is followed while running.
// - The duty setting register is four bits, readable and writable, spanning 30% to full on.
// - The pulse train has a constant period near 30 Hz and only its on-time varies.
// - The drive output is active high and driven both ways.
// - Duty codes map linearly from 30% at code 0 to 100% at code 15.
// - Only shutdown stops the drive; nothing else interrupts the pulsing.
`timescale 1ns/100ps
`include "fan_pwm_regs.vh"
module fan_pwm_duty_source_control #(
	parameter [31:0] START_CYCLES = `START_TIME_MS * `CLK_MHZ * 1000,
	parameter [31:0] PERIOD_CYCLES = (`CLK_MHZ * 1000000) / `PWM_FREQ_HZ,
	parameter OVERTEMP_ON_FAULT_PIN = 1
) (
	input wire i_clk,
	input wire i_rst,
	input wire i_duty_source_select,
	input wire i_shutdown_select,
	input wire i_duty_wr,
	input wire [3:0] i_duty_wdata,
	input wire [11:0] i_temp_level_mv,
	input wire i_temp_level_open,
	input wire i_fault_in,
	output reg [3:0] o_fan_duty_setting,
	output reg o_overtemp_flag,
	output reg o_start_active,
	output reg o_fault_out,
	output reg o_fault_oe,
	output reg o_fault_line_low,
	output wire o_pwm_drive_out
);
	// Control states
	localparam [1:0] ST_SHUTDOWN = 2'h0;
	localparam [1:0] ST_START = 2'h1;
	localparam [1:0] ST_RUN = 2'h2;

	reg [`LEVEL_W-1:0] level_meta;
	reg [`LEVEL_W-1:0] level_sync;
	reg open_meta;
	reg open_sync;
	reg fault_meta;
	reg fault_sync;
	reg [`LEVEL_W-1:0] level_prev;
	reg [`LEVEL_W-1:0] level_stable;
	reg [1:0] state;
	reg [1:0] next_state;
	reg [31:0] start_count;
	reg [`DUTY_W-1:0] duty;
	reg [`DUTY_W-1:0] next_duty;
	reg [`DUTY_W-1:0] analog_duty;
	reg [21:0] span_prod;
	reg [11:0] span_mv;
	reg overtemp;
	wire [63:0] on_prod;
	wire [31:0] on_cycles;
	wire pwm_run;

	function [`DUTY_W-1:0] code_duty;
		input [3:0] code;
		reg [15:0] step;
		begin
			step = ({12'h000, code} * `DUTY_SPAN) / `DUTY_CODE_STEPS;
			code_duty = `DUTY_FLOOR + step[`DUTY_W-1:0];
		end
	endfunction

	// Level and open-detect are sampled by an asynchronous converter
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			level_meta <= 12'h000;
			level_sync <= 12'h000;
			open_meta <= 1'b0;
			open_sync <= 1'b0;
			fault_meta <= 1'b1;
			fault_sync <= 1'b1;
			level_prev <= 12'h000;
			level_stable <= 12'h000;
		end else begin
			level_meta <= i_temp_level_mv;
			level_sync <= level_meta;
			open_meta <= i_temp_level_open;
			open_sync <= open_meta;
			fault_meta <= i_fault_in;
			fault_sync <= fault_meta;
			// Bits of a changing word may land a cycle apart; take only a repeated value
			level_prev <= level_sync;
			if (level_sync == level_prev) begin
				level_stable <= level_sync;
			end
		end
	end

	// Duty setting register
	// Write strobe is on this clock, so no sync
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_fan_duty_setting <= `DUTY_SET_RESET;
		end else if (i_duty_wr) begin
			o_fan_duty_setting <= i_duty_wdata;
		end
	end

	// Analog level to duty
	always @* begin
		span_mv = level_stable - `LEVEL_LOW_MV;
		span_prod = {10'h000, span_mv} * {12'h000, `LEVEL_GAIN};
		overtemp = (level_stable > `LEVEL_OVERTEMP_MV);
		// Open input falls back to the power-on default code
		if (open_sync) begin
			analog_duty = code_duty(`DUTY_SET_RESET);
		end else if (level_stable < `LEVEL_LOW_MV) begin
			analog_duty = `DUTY_FLOOR;
		end else if (level_stable >= `LEVEL_OVERTEMP_MV) begin
			analog_duty = `DUTY_FULL;
		end else begin
			analog_duty = `DUTY_FLOOR + span_prod[20:10];
		end
	end

	// Start-up and shutdown sequencing
	always @* begin
		next_state = state;
		case (state)
			ST_SHUTDOWN: begin
				if (!i_shutdown_select) begin
					next_state = ST_START;
				end
			end
			ST_START: begin
				if (i_shutdown_select) begin
					next_state = ST_SHUTDOWN;
				end else if (start_count == START_CYCLES - 32'h0000_0001) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				// Speed faults never stop the drive, only shutdown does
				if (i_shutdown_select) begin
					next_state = ST_SHUTDOWN;
				end
			end
			// Unused code recovers into a fresh start
			default: begin
				next_state = ST_START;
			end
		endcase
	end

	// Duty source choice, followed live while running
	always @* begin
		if (state != ST_RUN) begin
			next_duty = `DUTY_FULL;
		end else if (i_duty_source_select == `SOURCE_REGISTER) begin
			next_duty = code_duty(o_fan_duty_setting);
		end else begin
			next_duty = analog_duty;
		end
	end

	// Start timer runs only while the start state holds
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= ST_START;
			start_count <= 32'h0000_0000;
			duty <= `DUTY_FULL;
			o_start_active <= 1'b1;
		end else begin
			state <= next_state;
			duty <= next_duty;
			o_start_active <= (next_state == ST_START);
			if (next_state == ST_START && state == ST_START) begin
				start_count <= start_count + 32'h0000_0001;
			end else begin
				start_count <= 32'h0000_0000;
			end
		end
	end

	// Over-temperature status and fault line
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_overtemp_flag <= 1'b0;
			o_fault_out <= 1'b0;
			o_fault_oe <= 1'b0;
			o_fault_line_low <= 1'b0;
		end else begin
			// Live level, held off while the input is open
			o_overtemp_flag <= overtemp && !open_sync;
			o_fault_out <= 1'b0;
			// Open-drain: only ever pulls low
			o_fault_oe <= (OVERTEMP_ON_FAULT_PIN != 0) && overtemp && !open_sync;
			o_fault_line_low <= !fault_sync;
		end
	end

	// On-time in clocks: period times duty over 1024
	assign on_prod = {32'h0000_0000, PERIOD_CYCLES} * {53'h0, duty};
	assign on_cycles = on_prod[41:10];
	assign pwm_run = (state != ST_SHUTDOWN);

	// Boundary timing lives in the generator
	pwm_period_gen #(
		.PERIOD_CYCLES(PERIOD_CYCLES)
	) u_pwm (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_run(pwm_run),
		.i_on_cycles(on_cycles),
		.o_pwm(o_pwm_drive_out),
		.o_period_start()
	);
endmodule // fan_pwm_duty_source_control

// file: design/fan_pwm_regs.vh
// Constants for the fan PWM duty source controller
`ifndef FAN_PWM_REGS_VH
`define FAN_PWM_REGS_VH

// Clock and timing
`define CLK_MHZ 100
`define START_TIME_MS 1000
`define PWM_FREQ_HZ 30

// Duty scale: full on equals DUTY_FULL
`define DUTY_W 11
`define DUTY_FULL 11'h0_400
`define DUTY_FLOOR 11'h0_133
`define DUTY_SPAN 16'h0_2CD
`define DUTY_CODE_STEPS 16'h0_00F

// Analog level thresholds in millivolts
`define LEVEL_W 12
`define LEVEL_LOW_MV 12'h0_654
`define LEVEL_OVERTEMP_MV 12'h0_A28
// Span gain 717/980 as a fraction of 1024
`define LEVEL_GAIN 10'h2_ED

// Duty setting register
`define DUTY_SET_W 4
`define DUTY_SET_RESET 4'h2
`define SOURCE_SELECT_RESET 1'b0
`define SOURCE_ANALOG 1'b0
`define SOURCE_REGISTER 1'b1

`endif

// file: design/pwm_period_gen.v
// Fixed-period PWM generator with duty latched at the period boundary
`timescale 1ns/100ps
module pwm_period_gen #(
	parameter [31:0] PERIOD_CYCLES = 32'd3333333
) (
	input wire i_clk,
	input wire i_rst,
	input wire i_run,
	input wire [31:0] i_on_cycles,
	output reg o_pwm,
	output reg o_period_start
);
	reg [31:0] count;
	reg [31:0] on_cycles;

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			count <= 32'h0000_0000;
			// Full on until the first boundary, as power-up drive needs
			on_cycles <= 32'hFFFF_FFFF;
			o_pwm <= 1'b0;
			o_period_start <= 1'b0;
		end else if (!i_run) begin
			count <= 32'h0000_0000;
			on_cycles <= i_on_cycles;
			o_pwm <= 1'b0;
			o_period_start <= 1'b0;
		end else begin
			o_period_start <= (count == 32'h0000_0000);
			if (count == PERIOD_CYCLES - 32'h0000_0001) begin
				count <= 32'h0000_0000;
				// New on-time only at the boundary, never mid-pulse
				on_cycles <= i_on_cycles;
			end else begin
				count <= count + 32'h0000_0001;
			end
			o_pwm <= (count < on_cycles);
		end
	end
endmodule // pwm_period_gen

// file: dv/fan_pwm_checker_assertions.sv
// Port-level assertions for the fan PWM controller
`timescale 1ns/100ps
module fan_pwm_checker #(
	parameter [31:0] START_CYCLES = 32'h0,
	parameter [31:0] PERIOD_CYCLES = 32'h0
) (
	input wire i_clk,
	input wire i_rst,
	input wire i_shutdown_select,
	input wire i_duty_wr,
	input wire [3:0] i_duty_wdata,
	input wire [11:0] i_temp_level_mv,
	input wire i_temp_level_open,
	input wire [3:0] o_fan_duty_setting,
	input wire o_overtemp_flag,
	input wire o_start_active,
	input wire o_fault_oe,
	input wire o_pwm_drive_out
);
	reg [31:0] st_cnt;
	// Slack of one period: start may end on a boundary
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			st_cnt <= 32'h0;
		else
			st_cnt <= o_start_active ? st_cnt + 32'h1 : 32'h0;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_shut; i_shutdown_select[*3]; endsequence
	sequence s_hot; (i_temp_level_mv > 12'hA28 && !i_temp_level_open)[*6]; endsequence
	property p_shut_low; s_shut |-> !o_pwm_drive_out; endproperty
	property p_start_hold; o_start_active[*3] |-> o_pwm_drive_out; endproperty
	property p_start_len; st_cnt <= START_CYCLES + PERIOD_CYCLES; endproperty
	property p_ot_set; s_hot |-> o_overtemp_flag; endproperty
	property p_ot_clr; (i_temp_level_mv <= 12'hA28)[*6] |-> !o_overtemp_flag; endproperty
	property p_oe_follow; o_overtemp_flag[*3] |-> o_fault_oe; endproperty
	property p_duty_wr; i_duty_wr |=> o_fan_duty_setting == $past(i_duty_wdata); endproperty
	property p_duty_hold; !i_duty_wr |=> $stable(o_fan_duty_setting); endproperty
	a_shut_low: assert property (p_shut_low) else $error("drive active in shutdown");
	a_start_hold: assert property (p_start_hold) else $error("drive low in start");
	a_start_len: assert property (p_start_len) else $error("start too long");
	a_ot_set: assert property (p_ot_set) else $error("flag not set");
	a_ot_clr: assert property (p_ot_clr) else $error("flag not clear");
	a_oe_follow: assert property (p_oe_follow) else $error("fault line not pulled");
	a_duty_wr: assert property (p_duty_wr) else $error("duty write lost");
	a_duty_hold: assert property (p_duty_hold) else $error("duty changed");
endmodule // fan_pwm_checker

// file: dv/fan_switch_model.sv
// Fan switch and pulled-up fault wire beside the controller
`timescale 1ns/100ps
module fan_switch_model (
	input wire i_clk,
	input wire i_pwm,
	input wire i_fault_oe,
	input wire i_fault_out,
	output wire o_fault_line,
	output reg [31:0] o_on_cnt
);
	// Pull-up wins unless the controller sinks the line
	assign o_fault_line = (i_fault_oe && !i_fault_out) ? 1'b0 : 1'b1;
	initial o_on_cnt = 32'h0;
	always @(posedge i_clk)
		o_on_cnt <= o_on_cnt + {31'h0, i_pwm};
endmodule // fan_switch_model

// file: dv/testbench.sv
// Self-checking bench for the fan PWM controller
`timescale 1ns/100ps
module testbench;
	`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
		$display("wrong value t=%0t got %h exp %h", $time, a, e); end end
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg sel = 1'b0;
	reg sd = 1'b0;
	reg wr = 1'b0;
	reg [3:0] wd = 4'h0;
	reg [11:0] mv = 12'h0;
	reg open = 1'b1;
	wire fl, overtemp_flag, start, fout, foe, fll, pwm;
	wire [3:0] dset;
	wire [31:0] on_cnt;
	int error_cnt = 0;
	int cmp_count = 0;
	fan_pwm_duty_source_control #(.START_CYCLES(32'hC8), .PERIOD_CYCLES(32'h64)) u_dut (.i_clk(clk),
		.i_rst(rst), .i_duty_source_select(sel), .i_shutdown_select(sd), .i_duty_wr(wr), .i_duty_wdata(wd),
		.i_temp_level_mv(mv), .i_temp_level_open(open), .i_fault_in(fl), .o_fan_duty_setting(dset),
		.o_overtemp_flag(overtemp_flag), .o_start_active(start), .o_fault_out(fout), .o_fault_oe(foe),
		.o_fault_line_low(fll), .o_pwm_drive_out(pwm));
	fan_switch_model u_fan (.i_clk(clk), .i_pwm(pwm), .i_fault_oe(foe), .i_fault_out(fout),
		.o_fault_line(fl), .o_on_cnt(on_cnt));
	initial forever #5 clk = ~clk;
	function [31:0] on_code(input [31:0] c);
		on_code = (32'h64 * (32'h133 + c * 32'h2CD / 32'hF)) >> 10;
	endfunction
	// Any 100-cycle window of a settled train holds one on-time
	task run_per(input [31:0] exp);
		reg [31:0] c0;
		repeat (300) @(negedge clk);
		c0 = on_cnt;
		repeat (100) @(negedge clk);
		`CHK(on_cnt - c0, exp)
	endtask
	task t_start;
		reg [31:0] c0;
		repeat (20) @(negedge clk);
		`CHK(dset, 4'h2)
		`CHK(start, 1'b1)
		c0 = on_cnt;
		repeat (100) @(negedge clk);
		`CHK(on_cnt - c0, 32'h64)
		run_per(32'h27);
		`CHK(start, 1'b0)
	endtask
	task t_reg;
		sel = 1'b1;
		for (int c = 0; c < 16; c++) begin
			wd = c[3:0];
			wr = 1'b1;
			@(negedge clk);
			wr = 1'b0;
			`CHK(dset, c[3:0])
			run_per(on_code(c));
		end
	endtask
	task t_analog;
		sel = 1'b0;
		open = 1'b0;
		mv = 12'h3E8;
		run_per(32'h1D);
		mv = 12'h83E;
		run_per(32'h40);
		mv = 12'hBB8;
		run_per(32'h64);
		`CHK(overtemp_flag, 1'b1)
		`CHK(fll, 1'b1)
		`CHK(foe, 1'b1)
		`CHK(fout, 1'b0)
		mv = 12'h7D0;
		run_per(32'h39);
		`CHK(overtemp_flag, 1'b0)
		`CHK(foe, 1'b0)
		`CHK(fll, 1'b0)
	endtask
	task t_shut;
		reg [31:0] c0;
		sd = 1'b1;
		repeat (10) @(negedge clk);
		c0 = on_cnt;
		repeat (100) @(negedge clk);
		`CHK(on_cnt - c0, 32'h0)
		sd = 1'b0;
		repeat (3) @(negedge clk);
		`CHK(start, 1'b1)
		c0 = on_cnt;
		repeat (100) @(negedge clk);
		`CHK(on_cnt - c0, 32'h64)
	endtask
	task finish_test;
		if (error_cnt == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		t_start;
		t_reg;
		t_analog;
		t_shut;
		finish_test;
	end
	initial begin
		#500000;
		error_cnt++;
		finish_test;
	end
endmodule // testbench
bind fan_pwm_duty_source_control fan_pwm_checker #(.START_CYCLES(START_CYCLES), .PERIOD_CYCLES(PERIOD_CYCLES))
	u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_shutdown_select(i_shutdown_select), .i_duty_wr(i_duty_wr),
	.i_duty_wdata(i_duty_wdata), .i_temp_level_mv(i_temp_level_mv), .i_temp_level_open(i_temp_level_open),
	.o_fan_duty_setting(o_fan_duty_setting), .o_overtemp_flag(o_overtemp_flag),
	.o_start_active(o_start_active), .o_fault_oe(o_fault_oe), .o_pwm_drive_out(o_pwm_drive_out));
